// file: design/buck_setpoint_ramp_protect_ctrl.sv
// Setpoint ramp, mode, protection and register file of the step-down converter.
`timescale 1ns/1ns
`include "buck_ctrl_map.svh"
module buck_setpoint_ramp_protect_ctrl
    import buck_ctrl_pkg::*;
#(
    parameter int PWM_PERIOD = 10,  // PWM period is this plus one wait cycle
    parameter int HS_CYCLES  = 4    // High-side on cycles per pulse
) (
    input  wire logic       clk_in,            // 25 MHz core clock
    input  wire logic       rst_n_in,          // Async reset, active low
    input  wire logic       enable_pin_in,     // Enable pin
    input  wire logic       preset_select_pin_in, // Preset choice pin
    input  wire logic       analog_supply_uvlo_in, // Analog supply dropout
    input  wire logic       vdd_uvlo_in,       // Logic supply undervoltage
    input  wire logic       temp_warn_in,      // Die above warning level
    input  wire logic       temp_hot_in,       // Die above shutdown level
    input  wire logic       temp_cool_in,      // Die at or below release
    input  wire logic       light_load_in,     // Load low enough for PFM
    input  wire logic       out_low_in,        // Output below setpoint
    input  wire logic       peak_trip_in,      // Peak current limit tripped
    input  wire logic       ls_fwd_low_in,     // Low-side current below limit
    input  wire logic       zero_cross_in,     // Inductor current at zero
    input  wire logic       neg_limit_in,      // Negative current limit hit
    input  wire logic       link_clk_in,       // Serial front end clock
    input  wire logic       link_req_in,       // Command strobe, link clock
    input  wire link_cmd_t  link_cmd_in,       // Command fields
    output logic [6:0]      setpoint_code_out, // Present voltage code
    output logic            hs_on_out,         // High-side switch gate
    output logic            ls_on_out,         // Low-side switch gate
    output logic            pfm_active_out,    // Pulse frequency operation
    output logic            power_on_out,      // Power stage running
    output logic            link_busy_out,     // Command in flight
    output logic            link_done_out,     // Command finished pulse
    output logic [7:0]      link_rdata_out     // Read answer
);
    if (HS_CYCLES < 1 || HS_CYCLES >= PWM_PERIOD || PWM_PERIOD > 255) begin
        $error("HS_CYCLES must be 1 .. PWM_PERIOD-1, PWM_PERIOD <= 255");
    end

    localparam int NPIN = 13;

    // Ramp interval for one step, cycles; single means the 10 mV step
    function automatic logic [11:0] step_cycles(input logic [2:0] rate,
                                                input logic single);
        int ns;
        int cyc;
        ns = (`RAMP_STEP20_NS << rate) >> single;
        cyc = ns / `CLK_PERIOD_NS;
        if (cyc < 1) begin
            cyc = 1;
        end
        return cyc[11:0];
    endfunction

    logic [NPIN-1:0] pin_meta_reg;   // First synchroniser stage
    logic [NPIN-1:0] pin_sync_reg;   // Second synchroniser stage
    logic [7:0]      preset0_reg;    // Preset zero: mode and code
    logic [7:0]      preset1_reg;    // Preset one: mode and code
    logic [2:0]      ramp_rate_reg;  // Ramp rate field
    logic            fall_ps_reg;    // Falling ramp in power save
    logic            warn_flag_reg;  // Thermal warning flag
    logic            tsd_flag_reg;   // Thermal shutdown flag, sticky
    logic            tsd_active_reg; // Shutdown in force
    logic [11:0]     ramp_cnt_reg;   // Wait before next step
    logic            limit_hold_reg; // Low side held after peak trip
    sw_state_t       sw_state_reg;   // Switching phase
    logic [7:0]      phase_cnt_reg;  // Cycles since the high-side pulse began
    logic [7:0]      rdata_reg;      // Read answer, core domain
    logic            ack_tgl_reg;    // Command done toggle
    logic [2:0]      req_sync_reg;   // Request toggle crossing
    link_cmd_t       cmd_hold_reg;   // Command held during handshake
    logic            req_tgl_reg;    // Request toggle, link domain
    logic [2:0]      ack_sync_reg;   // Done toggle crossing

    logic en_s, sel_s, ana_uv_s, vdd_uv_s, warn_s, hot_s, cool_s;
    logic light_s, low_s, peak_s, fwd_low_s, zero_s, neg_s;
    assign {en_s, sel_s, ana_uv_s, vdd_uv_s, warn_s, hot_s, cool_s,
            light_s, low_s, peak_s, fwd_low_s, zero_s, neg_s} = pin_sync_reg;

    logic       reg_clear;   // Either supply dropped out
    logic       run;         // Stage allowed to switch
    logic [7:0] active;      // Selected preset
    logic [6:0] target;      // Selected voltage code
    logic       fpwm;        // Forced PWM in effect
    logic       pfm_now;     // PFM operation allowed now
    logic       falling;     // Setpoint above target
    logic       enforced;    // Slope must be followed
    logic [6:0] gap;         // Codes still to travel
    logic       cmd_seen;    // New command arrived
    logic       tsd_clear;   // Host clears shutdown flag
    assign reg_clear = ana_uv_s | vdd_uv_s;                  // see RULE22
    assign run       = en_s & ~tsd_active_reg & ~ana_uv_s;   // see RULE25
    assign active    = sel_s ? preset1_reg : preset0_reg;    // see RULE23
    assign target    = active[6:0];                          // see RULE1
    assign fpwm      = active[`MODE_BIT];                    // see RULE2
    assign pfm_now   = ~fpwm & light_s;                      // see RULE11
    assign falling   = setpoint_code_out > target;
    assign enforced  = ~falling | fpwm | fall_ps_reg;        // see RULE9
    assign gap       = falling ? setpoint_code_out - target
                               : target - setpoint_code_out;
    assign cmd_seen  = req_sync_reg[2] ^ req_sync_reg[1];
    assign tsd_clear = cmd_seen & cmd_hold_reg.write
                     & (cmd_hold_reg.addr == `STATUS_OFS)
                     & cmd_hold_reg.wdata[`TSD_BIT];

    // Two-stage synchronisers for every pin
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {enable_pin_in, preset_select_pin_in,
                             analog_supply_uvlo_in, vdd_uvlo_in,
                             temp_warn_in, temp_hot_in, temp_cool_in,
                             light_load_in, out_low_in, peak_trip_in,
                             ls_fwd_low_in, zero_cross_in, neg_limit_in};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Link side: take a command, hold it, toggle the request
    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cmd_hold_reg   <= '0;
            req_tgl_reg    <= 1'b0;
            ack_sync_reg   <= '0;
            link_busy_out  <= 1'b0;
            link_done_out  <= 1'b0;
            link_rdata_out <= 8'h00;
        end else begin
            ack_sync_reg  <= {ack_sync_reg[1:0], ack_tgl_reg};
            link_done_out <= 1'b0;
            if (link_busy_out && (ack_sync_reg[2] ^ ack_sync_reg[1])) begin
                // Read answer is stable: core holds it until next command
                link_busy_out  <= 1'b0;
                link_done_out  <= 1'b1;
                link_rdata_out <= rdata_reg;
            end else if (!link_busy_out && link_req_in) begin
                cmd_hold_reg  <= link_cmd_in;
                req_tgl_reg   <= ~req_tgl_reg;
                link_busy_out <= 1'b1;
            end
        end
    end

    // Core side request crossing; held command is stable while busy
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_sync_reg <= '0;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
        end
    end

    // Register file; supply dropout restores defaults
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            preset0_reg   <= `PRESET_ZERO_RST;
            preset1_reg   <= `PRESET_ONE_RST;
            ramp_rate_reg <= `RAMP_CTRL_RST;
            fall_ps_reg   <= 1'b0;
            rdata_reg     <= 8'h00;
            ack_tgl_reg   <= 1'b0;
        end else if (reg_clear) begin                     // see RULE21
            preset0_reg   <= `PRESET_ZERO_RST;            // see RULE22
            preset1_reg   <= `PRESET_ONE_RST;
            ramp_rate_reg <= `RAMP_CTRL_RST;
            fall_ps_reg   <= 1'b0;
            rdata_reg     <= 8'h00;
            if (cmd_seen) begin
                // Answer a command lost to dropout so the link never hangs
                ack_tgl_reg <= ~ack_tgl_reg;
            end
        end else if (cmd_seen) begin
            ack_tgl_reg <= ~ack_tgl_reg;
            if (cmd_hold_reg.write) begin
                // Writes land at once; active preset retargets the ramp
                case (cmd_hold_reg.addr)
                    `PRESET_ZERO_OFS: begin
                        preset0_reg <= cmd_hold_reg.wdata;  // see RULE6
                    end
                    `PRESET_ONE_OFS: begin
                        preset1_reg <= cmd_hold_reg.wdata;  // see RULE10
                    end
                    `RAMP_CTRL_OFS: begin
                        ramp_rate_reg <= cmd_hold_reg.wdata[2:0]; // see RULE3
                        fall_ps_reg   <= cmd_hold_reg.wdata[`FALL_PS_BIT];
                    end
                    default: begin
                        // Status and unmapped writes store nothing here
                    end
                endcase
            end else begin
                case (cmd_hold_reg.addr)
                    `PRESET_ZERO_OFS: rdata_reg <= preset0_reg;
                    `PRESET_ONE_OFS:  rdata_reg <= preset1_reg;
                    `RAMP_CTRL_OFS:   rdata_reg <= {4'h0, fall_ps_reg,
                                                    ramp_rate_reg};
                    `STATUS_OFS:      rdata_reg <= {6'h00, tsd_flag_reg,
                                                    warn_flag_reg};
                    default:          rdata_reg <= 8'h00;  // Unmapped
                endcase
            end
        end
    end

    // Thermal flags and shutdown with hysteresis; link keeps working
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            warn_flag_reg  <= 1'b0;
            tsd_flag_reg   <= 1'b0;
            tsd_active_reg <= 1'b0;
        end else begin
            warn_flag_reg <= warn_s;                       // see RULE17
            if (hot_s) begin
                tsd_active_reg <= 1'b1;                    // see RULE18
            end else if (cool_s) begin
                tsd_active_reg <= 1'b0;                    // see RULE19
            end
            // Set beats a clear arriving in the same cycle
            if (hot_s) begin
                tsd_flag_reg <= 1'b1;                      // see RULE20
            end else if (reg_clear || tsd_clear) begin
                tsd_flag_reg <= 1'b0;
            end
        end
    end

    // Setpoint ramp: first step at once, then one step per interval
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setpoint_code_out <= 7'h00;
            ramp_cnt_reg      <= 12'h000;
        end else if (!run) begin
            // Restart always begins at the minimum code
            setpoint_code_out <= 7'h00;                    // see RULE24
            ramp_cnt_reg      <= 12'h000;
        end else if (setpoint_code_out == target) begin
            ramp_cnt_reg <= 12'h000;
        end else if (!enforced) begin
            // Power-save fall without fall_ps_reg is left to the load; no slope held
            setpoint_code_out <= target;                   // see RULE9
        end else if (ramp_cnt_reg == 12'h000) begin
            // Toward new target, either direction; see RULE7 RULE8 RULE27
            if (gap >= 7'h02) begin
                setpoint_code_out <= falling ? setpoint_code_out - 7'h02
                                             : setpoint_code_out + 7'h02;
            end else begin
                setpoint_code_out <= falling ? setpoint_code_out - 7'h01
                                             : setpoint_code_out + 7'h01;
            end                                            // see RULE5
            ramp_cnt_reg <= step_cycles(ramp_rate_reg, gap < 7'h02)
                          - 12'h001;                       // see RULE4 RULE26
        end else begin
            ramp_cnt_reg <= ramp_cnt_reg - 12'h001;
        end
    end

    // Switch sequencing; high side on for HS_CYCLES cycles unless a peak trip ends it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_state_reg   <= SW_OFF;
            phase_cnt_reg  <= 8'h00;
            limit_hold_reg <= 1'b0;
            hs_on_out      <= 1'b0;
            ls_on_out      <= 1'b0;
            pfm_active_out <= 1'b0;
            power_on_out   <= 1'b0;
        end else begin
            pfm_active_out <= run & pfm_now;               // see RULE13
            power_on_out   <= run;
            phase_cnt_reg  <= phase_cnt_reg + 8'h01;
            if (!run) begin
                // Stage off at once for shutdown, enable low or analog supply dropout
                sw_state_reg   <= SW_OFF;                  // see RULE18 RULE21
                limit_hold_reg <= 1'b0;
                hs_on_out      <= 1'b0;
                ls_on_out      <= 1'b0;
            end else begin
                case (sw_state_reg)
                    SW_OFF: begin
                        sw_state_reg <= SW_WAIT;
                        phase_cnt_reg <= 8'h00;
                    end
                    SW_HIGH: begin
                        if (peak_s) begin
                            sw_state_reg   <= SW_LOW;      // see RULE14
                            limit_hold_reg <= 1'b1;
                            hs_on_out      <= 1'b0;
                            ls_on_out      <= 1'b1;
                        end else if (phase_cnt_reg >= 8'(HS_CYCLES - 1)) begin
                            sw_state_reg <= SW_LOW;
                            hs_on_out    <= 1'b0;
                            ls_on_out    <= 1'b1;
                        end
                    end
                    SW_LOW: begin
                        if (limit_hold_reg) begin
                            // Hold low side until its current drops
                            if (fwd_low_s) begin
                                limit_hold_reg <= 1'b0;    // see RULE15
                            end
                        end else if (pfm_now ? zero_s : neg_s) begin
                            sw_state_reg <= SW_WAIT;       // see RULE16
                            ls_on_out    <= 1'b0;
                        end else if (phase_cnt_reg >=
                                     8'(PWM_PERIOD - 1)) begin
                            sw_state_reg <= SW_WAIT;
                            ls_on_out    <= 1'b0;
                        end
                    end
                    SW_WAIT: begin
                        // PFM fires only on demand; PWM keeps its period
                        if (pfm_now ? low_s : 1'b1) begin  // see RULE12
                            sw_state_reg  <= SW_HIGH;
                            phase_cnt_reg <= 8'h00;
                            hs_on_out     <= 1'b1;
                        end
                    end
                    default: begin
                        sw_state_reg <= SW_OFF;
                        hs_on_out    <= 1'b0;
                        ls_on_out    <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Checks on the core clock; link checks on the link clock
    AST_STOPPED_AT_MIN: assert property (@(posedge clk_in) // see RULE24
        disable iff (!rst_n_in) !run |=> setpoint_code_out == 7'h00)
        else $error("setpoint not at minimum while stopped");
    AST_STEP_SIZE: assert property (@(posedge clk_in) // see RULE5
        disable iff (!rst_n_in) run && $past(enforced) && $past(run)
        |-> (setpoint_code_out - $past(setpoint_code_out) <= 7'h02)
         || ($past(setpoint_code_out) - setpoint_code_out <= 7'h02))
        else $error("setpoint step larger than two codes");
    AST_STEP_SPACING: assert property (@(posedge clk_in) // see RULE26
        disable iff (!rst_n_in)
        run && $past(run) && $past(enforced) && $changed(setpoint_code_out)
        |-> $past(ramp_cnt_reg) == 12'h000)
        else $error("setpoint stepped before interval ended");
    AST_SHUTDOWN_OFF: assert property (@(posedge clk_in) // see RULE18
        disable iff (!rst_n_in) tsd_active_reg |=> !hs_on_out && !ls_on_out
        ##1 !hs_on_out)
        else $error("switching during thermal shutdown");
    AST_PEAK_TRIP: assert property (@(posedge clk_in) // see RULE14
        disable iff (!rst_n_in) run && sw_state_reg == SW_HIGH && peak_s
        |=> !hs_on_out && ls_on_out)
        else $error("peak trip did not swap switches");
    AST_LS_HOLD: assert property (@(posedge clk_in) // see RULE15
        disable iff (!rst_n_in) run && limit_hold_reg && !fwd_low_s
        |=> ls_on_out || !run)
        else $error("low side released early");
    AST_FPWM_NO_PFM: assert property (@(posedge clk_in) // see RULE13
        disable iff (!rst_n_in) fpwm |=> !pfm_active_out)
        else $error("PFM entered in forced PWM");
    AST_TSD_STICKY: assert property (@(posedge clk_in) // see RULE20
        disable iff (!rst_n_in) tsd_flag_reg && !tsd_clear && !reg_clear
        |=> tsd_flag_reg)
        else $error("shutdown flag dropped without clear");
    AST_UVLO_DEFAULTS: assert property (@(posedge clk_in) // see RULE22
        disable iff (!rst_n_in) reg_clear
        |=> preset0_reg == `PRESET_ZERO_RST && ramp_rate_reg == 3'h0)
        else $error("registers not restored on undervoltage");
    AST_LINK_BUSY: assert property (@(posedge link_clk_in) // see RULE6
        disable iff (!rst_n_in) link_req_in && !link_busy_out
        |=> link_busy_out)
        else $error("link command not taken");

    COV_RAMP_DONE: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        run && setpoint_code_out != target ##[1:1000]
        setpoint_code_out == target);
    COV_SHUTDOWN: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(tsd_active_reg));
    COV_PEAK: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(limit_hold_reg));
    COV_PFM_PULSE: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        pfm_now && sw_state_reg == SW_WAIT && low_s);
    COV_LINK_DONE: cover property (@(posedge link_clk_in)
        disable iff (!rst_n_in) link_done_out);
endmodule

// file: common/buck_ctrl_map.svh
// Register offsets, field positions, reset values and timing counts.
// How it works
// (RULE1) Seven-bit code: 500 mV plus 10 mV steps
// (RULE2) Bit 7 of each preset picks mode
// (RULE3) One ramp rate serves both presets
// (RULE4) Slope is 32 mV/us halved per code
// (RULE5) Steps of 20 mV, last 10 mV
// (RULE6) Write to active preset starts ramp
// (RULE7) Forced PWM ramps both directions at slope
// (RULE8) Power save ramps upward at slope
// (RULE9) Falling slope in power save needs bit
// (RULE10) Host may change active preset mode
// (RULE11) Power save switches PWM and PFM itself
// (RULE12) PFM pulses only when output sags
// (RULE13) Forced PWM never enters PFM
// (RULE14) Peak trip: high side off, low on
// (RULE15) Low side holds until forward limit clears
// (RULE16) PFM stops at zero; PWM negative limit
// (RULE17) Warning flag follows warning comparator
// (RULE18) Shutdown stops stage, keeps registers, link
// (RULE19) Restart only after cool release threshold
// (RULE20) Shutdown flag latched until host clears
// (RULE21) Analog undervoltage: stop stage, reset registers
// (RULE22) Logic undervoltage resets all registers
// (RULE23) Select pin low preset zero, high one
// (RULE24) Enable ramps up from minimum voltage
// (RULE25) Enable high runs, low stops
// (RULE26) Step interval is step over rate
// (RULE27) Select change ramps toward new preset
`ifndef BUCK_CTRL_MAP_SVH
`define BUCK_CTRL_MAP_SVH
`define PRESET_ZERO_OFS    8'h00
`define PRESET_ONE_OFS     8'h01
`define RAMP_CTRL_OFS      8'h02
`define STATUS_OFS         8'h03
`define MODE_BIT           7
`define FALL_PS_BIT        3
`define WARN_BIT           0
`define TSD_BIT            1
`define PRESET_ZERO_RST    8'h46
`define PRESET_ONE_RST     8'h42
`define RAMP_CTRL_RST      3'h0
`define CLK_PERIOD_NS      40
`define RAMP_STEP20_NS     625
`endif

// file: common/buck_ctrl_pkg.sv
// Types shared by the converter control block.
package buck_ctrl_pkg;
    // One register command handed over from the serial front end
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } link_cmd_t;
    // Power stage switching phases
    typedef enum logic [1:0] {
        SW_OFF  = 2'b00,
        SW_HIGH = 2'b01,
        SW_LOW  = 2'b10,
        SW_WAIT = 2'b11
    } sw_state_t;
endpackage

// file: tb/link_host_model.sv
// Host model issuing single register commands over the link strobe.
`timescale 1ns/1ns
module link_host_model
    import buck_ctrl_pkg::*;
(
    input  wire logic       link_clk_in, // Link clock
    input  wire logic       busy_in,     // Command in flight
    input  wire logic       done_in,     // Command finished
    input  wire logic [7:0] rdata_in,    // Read answer
    output link_cmd_t       cmd_out,     // Command fields
    output logic            req_out      // One-cycle strobe
);
    initial begin
        req_out = 1'b0;
        cmd_out = '0;
    end
    // One command at a time; fields scrambled once the strobe drops
    task automatic xfer(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
        int n;
        @(posedge link_clk_in);
        while (busy_in !== 1'b0) @(posedge link_clk_in);
        req_out <= 1'b1;
        cmd_out <= '{w, a, d};
        @(posedge link_clk_in);
        req_out <= 1'b0;
        cmd_out <= ~cmd_out;
        for (n = 0; n < 40 && done_in !== 1'b1; n++) @(posedge link_clk_in);
        q = rdata_in;
    endtask
endmodule

// file: tb/buck_setpoint_ramp_protect_ctrl_bench.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module buck_setpoint_ramp_protect_ctrl_bench
    import buck_ctrl_pkg::*;
;
    logic clk_in = 1'b0, rst_n_in = 1'b0, link_clk_in = 1'b0, en = 1'b0;
    logic sel = 1'b0, ana = 1'b0, vdd = 1'b0, warn = 1'b0, hot = 1'b0;
    logic low = 1'b0, zero = 1'b0;
    logic cool = 1'b1, light = 1'b0, peak = 1'b0, fwd = 1'b0, seen = 1'b1;
    logic hs, ls, pfm, pon, busy, done, req;
    logic [6:0] sp, prev = 7'h00;
    logic [7:0] rdat, q;
    link_cmd_t cmd;
    int num_errors = 0, check_count = 0, cyc = 0, first_chg, last_chg;
    always #20 clk_in = ~clk_in;
    // Link clock of 15 ns, free of the core phase
    always begin
        #7 link_clk_in = 1'b1;
        #8 link_clk_in = 1'b0;
    end
    buck_setpoint_ramp_protect_ctrl buck_setpoint_ramp_protect_ctrl_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .enable_pin_in(en),
        .preset_select_pin_in(sel), .analog_supply_uvlo_in(ana),
        .vdd_uvlo_in(vdd), .temp_warn_in(warn), .temp_hot_in(hot),
        .temp_cool_in(cool), .light_load_in(light), .out_low_in(low),
        .peak_trip_in(peak), .ls_fwd_low_in(fwd), .zero_cross_in(zero),
        .neg_limit_in(1'b0),
        .link_clk_in(link_clk_in), .link_req_in(req), .link_cmd_in(cmd),
        .setpoint_code_out(sp), .hs_on_out(hs), .ls_on_out(ls),
        .pfm_active_out(pfm), .power_on_out(pon), .link_busy_out(busy),
        .link_done_out(done), .link_rdata_out(rdat));
    link_host_model link_host_model_i (.link_clk_in(link_clk_in),
        .busy_in(busy), .done_in(done), .rdata_in(rdat), .cmd_out(cmd),
        .req_out(req));
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, exp);
        link_host_model_i.xfer(1'b0, a, 8'h00, q);
        chk(16'(q), 16'(exp));
    endtask
    task automatic wr(input logic [7:0] a, d);
        link_host_model_i.xfer(1'b1, a, d, q);
    endtask
    // Write, wait for landing, compare first-to-last step span
    task automatic ramp(input logic [7:0] a, d, input int gap);
        int n;
        seen = 1'b0;
        wr(a, d);
        for (n = 0; n < 3000 && sp !== d[6:0]; n++) @(posedge clk_in);
        repeat (2) @(posedge clk_in);
        chk(16'(sp), 16'(d[6:0]));
        if (gap >= 0) chk(16'(last_chg - first_chg), 16'(gap));
    endtask
    // Step tracker; rising steps never exceed two codes
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        prev <= sp;
        if (sp !== prev) begin
            if (!seen) first_chg <= cyc;
            seen <= 1'b1;
            last_chg <= cyc;
            if (sp > prev + 7'd2) chk(16'(sp), 16'(prev + 7'd2));
        end
        if (cyc == 40000) begin
            num_errors++;
            results();
        end
    end
    task automatic results;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rd(8'h00, 8'h46);
        rd(8'h01, 8'h42);
        rd(8'h02, 8'h00);
        @(posedge clk_in);
        en <= 1'b1;
        ramp(8'h04, 8'h46, 510);
        rd(8'h04, 8'h00);
        wr(8'h02, 8'h09);
        ramp(8'h00, 8'h4a, 31);
        ramp(8'h00, 8'h46, 31);
        wr(8'h02, 8'h01);
        ramp(8'h00, 8'h42, 0);
        ramp(8'h00, 8'hc6, 31);
        ramp(8'h00, 8'hc2, 31);
        light <= 1'b1;
        peak <= 1'b1;
        repeat (30) @(posedge clk_in);
        chk(16'({pfm, hs, ls}), 16'h0001);
        peak <= 1'b0;
        repeat (30) @(posedge clk_in);
        chk(16'(ls), 16'h0001);
        fwd <= 1'b1;
        wr(8'h00, 8'h42);
        repeat (20) @(posedge clk_in);
        chk(16'(pfm), 16'h0001);
        chk(16'({hs, ls}), 16'h0000);
        low <= 1'b1;
        zero <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk(16'(hs), 16'h0001);
        while (hs !== 1'b0) @(posedge clk_in);
        @(posedge clk_in);
        chk(16'({hs, ls}), 16'h0000);
        wr(8'h01, 8'h45);
        @(posedge clk_in);
        sel <= 1'b1;
        ramp(8'h04, 8'h45, -1);
        warn <= 1'b1;
        hot <= 1'b1;
        cool <= 1'b0;
        repeat (8) @(posedge clk_in);
        chk(16'({pon, sp}), 16'h0000);
        rd(8'h01, 8'h45);
        hot <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk(16'(pon), 16'h0000);
        cool <= 1'b1;
        repeat (10) @(posedge clk_in);
        chk(16'(pon), 16'h0001);
        rd(8'h03, 8'h03);
        wr(8'h03, 8'h02);
        rd(8'h03, 8'h01);
        ana <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk(16'({pon, hs}), 16'h0000);
        ana <= 1'b0;
        rd(8'h01, 8'h42);
        wr(8'h00, 8'h11);
        @(posedge clk_in);
        vdd <= 1'b1;
        repeat (8) @(posedge clk_in);
        vdd <= 1'b0;
        rd(8'h00, 8'h46);
        results();
    end
endmodule
